/* File: design/swlm_write_lane.sv */
// Write port with lane masking for a four-beat double-rate SRAM
`timescale 1ns/10ps

module swlm_write_lane
(
    input  wire logic                              i_ref_clk,
    input  wire logic                              i_rstn,
    input  wire logic [1:0]                        i_org,
    input  wire logic                              i_write_port_select_n,
    input  wire logic [swlm_pkg::ADDR_W-1:0]       i_addr,
    input  wire logic                              i_beat_phase,
    input  wire logic [swlm_pkg::DATA_W-1:0]       i_data,
    input  wire logic [swlm_pkg::LANES-1:0]        i_byte_lane_select_n,
    input  wire logic [1:0]                        i_half_byte_lane_select_n,
    input  wire logic [swlm_pkg::ADDR_W-1:0]       i_rd_addr,
    output logic      [swlm_pkg::DATA_W-1:0]       o_rd_data,
    output logic                                   o_busy,
    output logic                                   o_beat_written
);
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic       wps_n_s1_reg;
    logic       wps_n_s2_reg;
    logic       phase_s1_reg;
    logic       phase_s2_reg;
    logic [swlm_pkg::DATA_W-1:0] data_s1_reg;
    logic [swlm_pkg::DATA_W-1:0] data_s2_reg;
    logic [swlm_pkg::LANES-1:0]  sel_s1_reg;
    logic [swlm_pkg::LANES-1:0]  sel_s2_reg;
    logic [1:0]                  nib_s1_reg;
    logic [1:0]                  nib_s2_reg;
    logic [1:0]                  org_s1_reg;
    logic [1:0]                  org_s2_reg;
    logic [swlm_pkg::ADDR_W-1:0] rdad_s1_reg;
    logic [swlm_pkg::ADDR_W-1:0] rdad_s2_reg;
    logic [swlm_pkg::ADDR_W-1:0] addr_s1_reg;
    logic [swlm_pkg::ADDR_W-1:0] addr_s2_reg;
    logic [swlm_pkg::LANES-1:0]  sel_mux;

    // The x8 part uses the half-byte selects; folded in only after syncing
    always_comb
    begin
        sel_mux = sel_s2_reg;
        if (swlm_pkg::swlm_org_t'(org_s2_reg) == swlm_pkg::SWLM_ORG_X8)
            sel_mux = {swlm_pkg::ALL_OFF[3:2], nib_s2_reg};
    end

    // Two flops on every pin; the second stage alone is read
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            wps_n_s1_reg <= 1'b1;
            wps_n_s2_reg <= 1'b1;
            phase_s1_reg <= 1'b0;
            phase_s2_reg <= 1'b0;
            data_s1_reg  <= swlm_pkg::ZERO_WORD;
            data_s2_reg  <= swlm_pkg::ZERO_WORD;
            sel_s1_reg   <= swlm_pkg::ALL_OFF;
            sel_s2_reg   <= swlm_pkg::ALL_OFF;
            nib_s1_reg   <= swlm_pkg::ALL_OFF[1:0];
            nib_s2_reg   <= swlm_pkg::ALL_OFF[1:0];
            org_s1_reg   <= swlm_pkg::SWLM_ORG_X36;
            org_s2_reg   <= swlm_pkg::SWLM_ORG_X36;
            rdad_s1_reg  <= '0;
            rdad_s2_reg  <= '0;
            addr_s1_reg  <= '0;
            addr_s2_reg  <= '0;
        end
        else
        begin
            wps_n_s1_reg <= i_write_port_select_n;
            wps_n_s2_reg <= wps_n_s1_reg;
            phase_s1_reg <= i_beat_phase;
            phase_s2_reg <= phase_s1_reg;
            data_s1_reg  <= i_data;
            data_s2_reg  <= data_s1_reg;
            sel_s1_reg   <= i_byte_lane_select_n;
            sel_s2_reg   <= sel_s1_reg;
            nib_s1_reg   <= i_half_byte_lane_select_n;
            nib_s2_reg   <= nib_s1_reg;
            org_s1_reg   <= i_org;
            org_s2_reg   <= org_s1_reg;
            rdad_s1_reg  <= i_rd_addr;
            rdad_s2_reg  <= rdad_s1_reg;
            addr_s1_reg  <= i_addr;
            addr_s2_reg  <= addr_s1_reg;
        end
    end

    // ****************************************
    // Burst sequencer
    // ****************************************
    typedef enum logic [1:0]
    {
        SWLM_IDLE  = 2'b00,
        SWLM_LOAD  = 2'b01,
        SWLM_DATA  = 2'b11
    } swlm_state_t;

    swlm_state_t                 state_reg;
    logic [1:0]                  beat_reg;
    logic [swlm_pkg::ADDR_W-1:0] waddr_reg;
    logic                        start;
    logic                        in_data;

    // Load edges only; a request right after one is dropped
    assign start   = !wps_n_s2_reg && !phase_s2_reg && (state_reg == SWLM_IDLE);
    assign in_data = (state_reg == SWLM_DATA);

    // Load cycle, then four data cycles, one per beat
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            state_reg <= SWLM_IDLE;
            beat_reg  <= swlm_pkg::BEAT_FIRST;
        end
        else
        begin
            unique case (state_reg)
                SWLM_IDLE:
                    if (start)
                        state_reg <= SWLM_LOAD;
                SWLM_LOAD:
                    if (phase_s2_reg)
                    begin
                        state_reg <= SWLM_DATA;
                        beat_reg  <= swlm_pkg::BEAT_FIRST;
                    end
                SWLM_DATA:
                begin
                    beat_reg <= beat_reg + 2'h1;
                    if (beat_reg == swlm_pkg::BEAT_LAST)
                        state_reg <= SWLM_IDLE;
                end
                default:
                    state_reg <= SWLM_IDLE;
            endcase
        end
    end

    // ****************************************
    // Array and masked write
    // ****************************************
    logic [swlm_pkg::DATA_W-1:0] mem [swlm_pkg::DEPTH];
    logic [swlm_pkg::DATA_W-1:0] merged;
    logic                        any_lane;
    logic                        wr_en;

    swlm_lane_merge u_merge
    (
        .i_org   (org_s2_reg),
        .i_sel_n (sel_mux),
        .i_old   (mem[waddr_reg]),
        .i_data  (data_s2_reg),
        .o_word  (merged),
        .o_any   (any_lane)
    );

    assign wr_en = in_data && any_lane;

    // Burst address, stepped once per beat
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            waddr_reg <= '0;
        else if (start)
            waddr_reg <= addr_s2_reg;
        else if (in_data)
            waddr_reg <= waddr_reg + swlm_pkg::ADDR_ONE;
    end

    // Array word update; unselected lanes keep their bits
    always_ff @(posedge i_ref_clk)
    begin
        if (wr_en)
            mem[waddr_reg] <= merged;
    end

    // Status and read-back outputs, all registered
    always_ff @(posedge i_ref_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_busy         <= 1'b0;
            o_beat_written <= 1'b0;
            o_rd_data      <= swlm_pkg::ZERO_WORD;
        end
        else
        begin
            o_busy         <= (state_reg != SWLM_IDLE);
            o_beat_written <= wr_en;
            o_rd_data      <= mem[rdad_s2_reg];
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_load;
        start ##1 (state_reg == SWLM_LOAD);
    endsequence

    property p_burst_len;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        s_load ##1 in_data |-> in_data [*4] ##1 !in_data;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst not four beats");

    property p_no_back_to_back;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (in_data && !wps_n_s2_reg) |=> (state_reg != SWLM_LOAD)
            && (waddr_reg == $past(waddr_reg) + swlm_pkg::ADDR_ONE);
    endproperty
    a_no_back_to_back: assert property (p_no_back_to_back) else $error("second start taken");

    property p_outside_no_write;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        !in_data |=> !o_beat_written;
    endproperty
    a_outside_no_write: assert property (p_outside_no_write) else $error("write outside burst");

    property p_all_high;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (sel_mux == swlm_pkg::ALL_OFF) |-> !wr_en;
    endproperty
    a_all_high: assert property (p_all_high) else $error("write with all lanes off");

    property p_merge_x36_low;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (org_s2_reg == swlm_pkg::SWLM_ORG_X36 && sel_mux == 4'he)
            |-> merged == {mem[waddr_reg][35:9], data_s2_reg[8:0]};
    endproperty
    a_merge_x36_low: assert property (p_merge_x36_low) else $error("x36 low lane wrong");

    property p_x8_low;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (org_s2_reg == swlm_pkg::SWLM_ORG_X8 && sel_mux[1:0] == 2'h2)
            |-> merged[7:0] == {mem[waddr_reg][7:4], data_s2_reg[3:0]};
    endproperty
    a_x8_low: assert property (p_x8_low) else $error("x8 low nibble wrong");

    property p_x8_high;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (org_s2_reg == swlm_pkg::SWLM_ORG_X8 && sel_mux[1:0] == 2'h1)
            |-> merged[7:0] == {data_s2_reg[7:4], mem[waddr_reg][3:0]};
    endproperty
    a_x8_high: assert property (p_x8_high) else $error("x8 high nibble wrong");

    property p_written_flag;
        @(posedge i_ref_clk) disable iff (!i_rstn)
        (in_data && sel_mux != swlm_pkg::ALL_OFF && org_s2_reg == swlm_pkg::SWLM_ORG_X36)
            |=> o_beat_written;
    endproperty
    a_written_flag: assert property (p_written_flag) else $error("beat not written");
endmodule : swlm_write_lane

/* File: pkg/swlm_pkg.sv */
// Constants shared by the write lane masking block
package swlm_pkg;
    // Organisations
    typedef enum logic [1:0]
    {
        SWLM_ORG_X8  = 2'h0,
        SWLM_ORG_X9  = 2'h1,
        SWLM_ORG_X18 = 2'h2,
        SWLM_ORG_X36 = 2'h3
    } swlm_org_t;

    // Widest word and lane layout
    localparam int unsigned DATA_W      = 36;
    localparam int unsigned LANES       = 4;
    localparam int unsigned LANE_W      = 9;
    localparam int unsigned NIB_W       = 4;
    localparam int unsigned ADDR_W      = 4;
    localparam int unsigned DEPTH       = 16;
    localparam int unsigned BEATS       = 4;
    localparam logic [1:0]  BEAT_LAST   = 2'h3;
    localparam logic [1:0]  BEAT_FIRST  = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_ONE = 4'h1;
    localparam logic [DATA_W-1:0] ZERO_WORD = 36'h0;
    localparam logic [LANES-1:0]  ALL_OFF   = 4'hf;
endpackage : swlm_pkg

/* File: design/swlm_lane_merge.sv */
// Lane merge of one incoming beat into an old array word
`timescale 1ns/10ps
module swlm_lane_merge
(
    input  wire logic [1:0]                  i_org,
    input  wire logic [swlm_pkg::LANES-1:0]  i_sel_n,
    input  wire logic [swlm_pkg::DATA_W-1:0] i_old,
    input  wire logic [swlm_pkg::DATA_W-1:0] i_data,
    output logic      [swlm_pkg::DATA_W-1:0] o_word,
    output logic                             o_any
);
    // Per-bit write enable built from the lane selects
    logic [swlm_pkg::DATA_W-1:0] bit_en;

    // Lane to bit expansion, by organisation
    always_comb
    begin
        bit_en = swlm_pkg::ZERO_WORD;
        unique case (swlm_pkg::swlm_org_t'(i_org))
            swlm_pkg::SWLM_ORG_X8:
            begin
                bit_en[swlm_pkg::NIB_W-1:0] = {swlm_pkg::NIB_W{~i_sel_n[0]}};
                bit_en[2*swlm_pkg::NIB_W-1:swlm_pkg::NIB_W] =
                    {swlm_pkg::NIB_W{~i_sel_n[1]}};
            end
            swlm_pkg::SWLM_ORG_X9:
                bit_en[swlm_pkg::LANE_W-1:0] = {swlm_pkg::LANE_W{~i_sel_n[0]}};
            swlm_pkg::SWLM_ORG_X18:
            begin
                bit_en[swlm_pkg::LANE_W-1:0] = {swlm_pkg::LANE_W{~i_sel_n[0]}};
                bit_en[2*swlm_pkg::LANE_W-1:swlm_pkg::LANE_W] =
                    {swlm_pkg::LANE_W{~i_sel_n[1]}};
            end
            swlm_pkg::SWLM_ORG_X36:
            begin
                for (int l = 0; l < swlm_pkg::LANES; l++)
                begin
                    bit_en[l*swlm_pkg::LANE_W +: swlm_pkg::LANE_W] =
                        {swlm_pkg::LANE_W{~i_sel_n[l]}};
                end
            end
        endcase
    end

    // Selected lanes take new data, others keep old bits
    assign o_word = (i_data & bit_en) | (i_old & ~bit_en);
    assign o_any  = |bit_en;
endmodule : swlm_lane_merge

/* File: sim/swlm_ctrl_model.sv */
// Memory controller model driving the write port pins
`timescale 1ns/10ps
module swlm_ctrl_model
(
    input  wire logic        i_ref_clk,
    output logic             o_wps_n,
    output logic             o_phase,
    output logic [3:0]       o_addr,
    output logic [35:0]      o_data,
    output logic [3:0]       o_bsel_n,
    output logic [1:0]       o_nsel_n
);
    // ****************************************
    // Pin drive
    // ****************************************
    initial
    begin
        o_wps_n  = 1'b1;
        o_phase  = 1'b0;
        o_addr   = 4'h0;
        o_data   = 36'h0;
        o_bsel_n = 4'hf;
        o_nsel_n = 2'h3;
    end

    // Phase runs free, like the clock pair itself
    always @(negedge i_ref_clk)
        o_phase <= ~o_phase;

    // One burst; again asks for a second write on the next true edge
    task automatic burst(input logic [3:0] a, input logic [143:0] d,
                         input logic [23:0] s, input logic again);
        int k;
        // Wait for a complement edge so the request lands on a load edge
        do
            @(negedge i_ref_clk);
        while (!o_phase);
        o_wps_n <= 1'b0;
        o_addr  <= a;
        @(negedge i_ref_clk);
        o_wps_n <= 1'b1;
        o_addr  <= ~a;
        for (k = 0; k < 4; k++)
        begin
            @(negedge i_ref_clk);
            o_wps_n  <= ~(again && k == 0);
            o_addr   <= a + 4'h8;
            o_data   <= d[k*36 +: 36];
            o_bsel_n <= s[k*6 +: 4];
            o_nsel_n <= s[k*6+4 +: 2];
        end
        @(negedge i_ref_clk);
        // Released data toggles; selects left active to tempt a stray write
        o_wps_n  <= 1'b1;
        o_data   <= ~o_data;
        o_bsel_n <= 4'h0;
        o_nsel_n <= 2'h0;
    endtask
endmodule // swlm_ctrl_model

/* File: sim/swlm_write_lane_tb_top.sv */
// Self-checking bench for the write lane masking block
`timescale 1ns/10ps
module swlm_write_lane_tb_top;
    logic              i_ref_clk;
    logic              i_rstn;
    logic [1:0]        org;
    logic [3:0]        rd_addr;
    logic              wps_n, phase, busy, bw;
    logic [3:0]        addr, bsel_n;
    logic [1:0]        nsel_n;
    logic [35:0]       data, rd_data;
    logic [35:0]       ref_mem [16];
    int                mismatches;
    int                compares;
    localparam logic [143:0] PA = {36'h123456789, 36'habcdef012, 36'h3456789ab, 36'hcdef01234};

    // ****************************************
    // Structure
    // ****************************************
    swlm_write_lane DUT (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_org(org),
        .i_write_port_select_n(wps_n), .i_addr(addr), .i_beat_phase(phase), .i_data(data),
        .i_byte_lane_select_n(bsel_n), .i_half_byte_lane_select_n(nsel_n),
        .i_rd_addr(rd_addr), .o_rd_data(rd_data), .o_busy(busy), .o_beat_written(bw));
    swlm_ctrl_model ctrl (.i_ref_clk(i_ref_clk), .o_wps_n(wps_n), .o_phase(phase),
        .o_addr(addr), .o_data(data), .o_bsel_n(bsel_n), .o_nsel_n(nsel_n));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    // ****************************************
    // Checks and model of the array
    // ****************************************
    task automatic check_word(input string n, input logic [35:0] e, input logic [35:0] g);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic check_count(input string n, input int e, input int g);
        compares++;
        if (g != e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
        end
    endtask

    // Lanes a beat may touch; narrow organisations use only their low bits
    function automatic logic [35:0] lanes(input logic [1:0] o, input logic [5:0] s);
        case (o)
            swlm_pkg::SWLM_ORG_X8:  return {28'h0, {4{~s[5]}}, {4{~s[4]}}};
            swlm_pkg::SWLM_ORG_X9:  return {27'h0, {9{~s[0]}}};
            swlm_pkg::SWLM_ORG_X18: return {18'h0, {9{~s[1]}}, {9{~s[0]}}};
            default: return {{9{~s[3]}}, {9{~s[2]}}, {9{~s[1]}}, {9{~s[0]}}};
        endcase
    endfunction

    // Readback of all words; only the organisation's width is judged
    task automatic read_all();
        logic [35:0] w;
        w = lanes(org, 6'h0);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge i_ref_clk);
            rd_addr <= i[3:0];
            repeat (4) @(negedge i_ref_clk);
            // Words never written hold no known value yet
            if (!$isunknown(ref_mem[i]))
                check_word("array word", ref_mem[i] & w, rd_data & w);
        end
    endtask

    task automatic run_burst(input logic [1:0] o, input logic [3:0] a, input logic [143:0] d,
                             input logic [23:0] s, input logic again);
        int seen;
        int want;
        int bsy;
        logic [35:0] m;
        logic [3:0] ix;
        seen = 0;
        want = 0;
        bsy = 0;
        @(negedge i_ref_clk);
        org <= o;
        repeat (4) @(negedge i_ref_clk);
        for (int k = 0; k < 4; k++)
        begin
            m = lanes(o, s[k*6 +: 6]);
            ix = a + k[3:0];
            want += (m != 36'h0);
            ref_mem[ix] = (ref_mem[ix] & ~m) | (d[k*36 +: 36] & m);
        end
        fork
            ctrl.burst(a, d, s, again);
            repeat (16)
            begin
                @(negedge i_ref_clk);
                if (bw === 1'b1) seen++;
                if (busy === 1'b1) bsy++;
            end
        join
        check_count("beats written", want, seen);
        // One load cycle plus one cycle per beat
        check_count("busy cycles", int'(swlm_pkg::BEATS) + 1, bsy);
        check_word("busy", 36'h0, {35'h0, busy});
        read_all();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic sc_fill();
        for (int b = 0; b < 4; b++)
            run_burst(2'h3, 4'(b*4), b[0] ? ~PA : PA, 24'h0, 1'b0);
    endtask

    task automatic sc_x36();
        run_burst(2'h3, 4'h2, ~PA, {6'h07, 6'h0b, 6'h0d, 6'h0e}, 1'b0);
        run_burst(2'h3, 4'h6, PA, {6'h0f, 6'h05, 6'h0f, 6'h0a}, 1'b0);
    endtask

    task automatic sc_x18();
        run_burst(2'h2, 4'h5, PA, {6'h3c, 6'h3e, 6'h3d, 6'h3f}, 1'b0);
    endtask

    // Byte selects held active so only the nibble selects may decide
    task automatic sc_x8();
        run_burst(2'h0, 4'he, ~PA, {6'h00, 6'h20, 6'h10, 6'h30}, 1'b0);
    endtask

    task automatic sc_x9();
        run_burst(2'h1, 4'h9, PA, {6'h31, 6'h30, 6'h31, 6'h30}, 1'b0);
    endtask

    task automatic sc_refuse();
        run_burst(2'h3, 4'h0, ~PA, 24'h0, 1'b1);
    endtask

    task automatic end_sim();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (30000) @(posedge i_ref_clk);
        mismatches++;
        end_sim();
    end

    initial
    begin
        mismatches = 0;
        compares = 0;
        i_rstn = 1'b0;
        org = 2'h3;
        rd_addr = 4'h0;
        repeat (5) @(negedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (2) @(negedge i_ref_clk);
        sc_fill();
        sc_x36();
        sc_x18();
        sc_x8();
        sc_x9();
        sc_refuse();
        end_sim();
    end
endmodule // swlm_write_lane_tb_top
